//--- dv/ctc_bus_model.sv
// far side of the transceiver: the bus wire and the other nodes on it
// assumes the other nodes are summed up in one dominant request
`timescale 1ns/10ps
`default_nettype none

module ctc_bus_model (
  input  wire logic aclk,
  input  wire logic bus_tx_out,
  input  wire logic bus_drv_en,
  input  wire logic other_dom,
  output var logic  bus_rx_in
);
  initial bus_rx_in = 1'b1;
  // wired-and bus; a tristated driver adds nothing to it
  always @(posedge aclk) begin
    bus_rx_in <= !other_dom && (bus_tx_out || !bus_drv_en);
  end
endmodule
`default_nettype wire

//--- dv/ctc_checker.sv
// assertions on the ports of the bus transceiver control block
// assumes one clock, aclk, and the bind at the foot of this file
`include "ctc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ctc_checker (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  power_down,
  input wire ctc_pkg::ctc_pmode_t   pmode,
  input wire ctc_pkg::ctc_axi_req_t axi_req,
  input wire ctc_pkg::ctc_axi_rsp_t axi_rsp,
  input wire logic                  rx_data,
  input wire logic                  bus_tx_out,
  input wire logic                  bus_drv_en,
  input wire logic                  bus_wake_detected,
  input wire logic                  core_clk_run,
  input wire logic                  irq
);
  import ctc_pkg::*;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic       wr_go;
  logic       rd_go;
  // shadow of the mask, taken from bus writes on lane 0
  assign wr_go = axi_req.awvalid && axi_req.wvalid && axi_rsp.awready;
  assign rd_go = axi_req.arvalid && axi_rsp.arready;
  always_comb begin
    mask_d = mask_q;
    if (wr_go && axi_req.awaddr == `CTC_MASK_OFS && axi_req.wstrb[0])
      mask_d = axi_req.wdata[3:0];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || power_down)
      mask_q <= 4'h0;
    else
      mask_q <= mask_d;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || power_down);
  a_reset_values: assert property (
    $rose(aresetn) |-> !bus_drv_en && rx_data && bus_tx_out && !irq)
    else $error("outputs not at reset level");
  a_mask_blocks_irq: assert property (
    (mask_q == 4'h0) [*3] |-> !irq)
    else $error("irq while all sources masked");
  a_failsleep_off: assert property (
    (pmode == CTC_PM_FAILSLEEP) [*4] |-> !bus_drv_en && bus_tx_out && rx_data)
    else $error("driver active in fail-sleep");
  a_off_no_wake: assert property (
    (pmode == CTC_PM_FAILSLEEP) [*4] |-> !bus_wake_detected)
    else $error("wake seen while off");
  a_stop_silence: assert property (
    $past(pmode) == CTC_PM_ACTIVE && pmode == CTC_PM_STOP |-> core_clk_run [*8])
    else $error("clock dropped inside silence time");
  a_write_answer: assert property (
    wr_go |=> axi_rsp.bvalid)
    else $error("no write response");
  a_bvalid_holds: assert property (
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  a_read_answer: assert property (
    rd_go |=> $rose(axi_rsp.rvalid))
    else $error("no read response");
  a_unmapped_err: assert property (
    rd_go && axi_req.araddr > `CTC_MASK_OFS |=>
      axi_rsp.rresp == `CTC_RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind ctc_bus_transceiver ctc_checker ctc_checker_i (
  .aclk(aclk),
  .aresetn(aresetn),
  .power_down(power_down),
  .pmode(pmode),
  .axi_req(axi_req),
  .axi_rsp(axi_rsp),
  .rx_data(rx_data),
  .bus_tx_out(bus_tx_out),
  .bus_drv_en(bus_drv_en),
  .bus_wake_detected(bus_wake_detected),
  .core_clk_run(core_clk_run),
  .irq(irq)
);
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the bus transceiver control block
// assumes the bus model and the bound checker are compiled before it
`include "ctc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import ctc_pkg::*;
  logic         aclk;
  logic         aresetn;
  logic         wrst_n;
  logic         pdown;
  ctc_pmode_t   pm;
  logic         wk;
  logic         sil_t;
  logic         flt_t;
  logic         uv;
  logic         ot;
  logic [3:0]   txs;
  logic         dom;
  logic         rxb;
  ctc_axi_req_t req;
  ctc_axi_rsp_t rsp;
  logic         rxd;
  logic         txo;
  logic         drv;
  logic         bias;
  logic         wake;
  logic         clkr;
  logic         irq;
  int           failures;
  int           check_count;
  int           irq_n;
  int           cyc;
  integer       seed;
  logic [31:0]  d;
  logic [1:0]   r;

  // short timeouts keep the run brief
  ctc_bus_transceiver #(.TWAKE2_CYC(200), .BUS_TO_CYC(50), .TXD_TO_CYC(50))
    ctc_bus_transceiver_i (.aclk(aclk), .aresetn(aresetn),
    .wake_resetn(wrst_n), .power_down(pdown), .pmode(pm), .wake_en_in(wk),
    .silence_tick(sil_t), .filter_tick(flt_t), .supply_undervoltage_in(uv),
    .overtemp_in(ot), .tx_in_protocol(txs[0]), .tx_in_uart(txs[1]),
    .tx_in_timer(txs[2]), .tx_in_gpio(txs[3]), .bus_rx_in(rxb),
    .axi_req(req), .axi_rsp(rsp), .rx_data(rxd), .bus_tx_out(txo),
    .bus_drv_en(drv), .bus_bias_en(bias), .bus_wake_detected(wake),
    .core_clk_run(clkr), .irq(irq));
  ctc_bus_model ctc_bus_model_i (.aclk(aclk), .bus_tx_out(txo),
    .bus_drv_en(drv), .other_dom(dom), .bus_rx_in(rxb));

  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    sil_t <= 1'($random(seed));
    flt_t <= 1'($random(seed));
    if (irq === 1'b1)
      irq_n++;
    cyc++;
    if (cyc == 6000) begin
      failures++;
      final_report();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    do @(posedge aclk); while (!(rsp.awready && rsp.wready));
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    @(posedge aclk);
    req.bready <= 1'b1;
    do @(posedge aclk); while (!rsp.bvalid);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    @(posedge aclk);
    req.rready <= 1'b1;
    do @(posedge aclk); while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    rd(a);
    cmp(d & m, e);
  endtask

  function automatic logic [31:0] exp_opm(int p, int c);
    if (p == 0 && c[0] && c[2:1] == 2'h1)
      return 32'h1;
    if (p == 0 && c[0] && c[2:1] == 2'h3)
      return 32'h2;
    if (p == 3 || !c[3])
      return 32'h0;
    return 32'h3;
  endfunction

  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    seed = 32'hdc91_7602;
    {aclk, aresetn, wrst_n, pdown, wk, uv, ot, dom} = 8'h00;
    {failures, check_count, irq_n, cyc} = '0;
    pm = CTC_PM_ACTIVE;
    txs = 4'hf;
    req = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wrst_n <= 1'b1;
    @(posedge aclk);
    rd_chk(`CTC_CTRL_OFS, 32'hffff_ffff, 32'h0);
    rd_chk(`CTC_FLAGS_OFS, 32'hffff_ffff, 32'h0);
    rd_chk(`CTC_STAT_OFS, 32'h3, 32'h0);
    rd(8'h20);
    cmp(32'(r), 32'(`CTC_RESP_SLVERR));
    d = $random(seed);
    wr(`CTC_MASK_OFS, d);
    rd_chk(`CTC_MASK_OFS, 32'hffff_ffff, {28'h0, d[3:0]});
    $display("test reset and registers done");
    // every system power mode against every enable, mode field and wake-enable setting
    for (int p = 0; p < 4; p++)
      for (int c = 0; c < 16; c++) begin
        pm <= ctc_pmode_t'(p);
        wk <= c[3];
        wr(`CTC_CTRL_OFS, 32'(c[2:0]));
        repeat (3) @(posedge aclk);
        rd_chk(`CTC_STAT_OFS, 32'h3, exp_opm(p, c));
      end
    $display("test mode decode done");
    wr(`CTC_MASK_OFS, 32'h0);
    irq_n = 0;
    wr(`CTC_FORCE_OFS, 32'hf);
    rd_chk(`CTC_FLAGS_OFS, 32'hf, 32'hf);
    wr(`CTC_CLEAR_OFS, 32'hf);
    rd_chk(`CTC_FLAGS_OFS, 32'hf, 32'h0);
    wr(`CTC_MASK_OFS, 32'h1);
    wr(`CTC_FORCE_OFS, 32'h1);
    wr(`CTC_FORCE_OFS, 32'h3);
    repeat (2) @(posedge aclk);
    cmp(irq_n, 2);
    pm <= CTC_PM_ACTIVE;
    wk <= 1'b0;
    wr(`CTC_CTRL_OFS, 32'hf);
    wr(`CTC_CLEAR_OFS, 32'hf0f);
    wr(`CTC_MASK_OFS, 32'hf);
    cmp(32'(bias), 32'h1);
    irq_n = 0;
    dom <= 1'b1;
    repeat (80) @(posedge aclk);
    cmp(32'(rxd), 32'h0);
    dom <= 1'b0;
    rd_chk(`CTC_FLAGS_OFS, 32'h101, 32'h101);
    cmp(irq_n, 1);
    // one source stuck dominant must be cut off
    txs <= 4'he;
    repeat (80) @(posedge aclk);
    cmp(32'(txo), 32'h1);
    rd_chk(`CTC_FLAGS_OFS, 32'h202, 32'h202);
    txs <= 4'hf;
    wr(`CTC_CLEAR_OFS, 32'h303);
    for (int i = 0; i < 4; i++) begin
      txs <= ~(4'h1 << i);
      repeat (4) @(posedge aclk);
      cmp(32'(txo), 32'h0);
      txs <= 4'hf;
      @(posedge aclk);
    end
    ot <= 1'b1;
    uv <= 1'b1;
    repeat (3) @(posedge aclk);
    rd_chk(`CTC_FLAGS_OFS, 32'h1404, 32'h1404);
    ot <= 1'b0;
    uv <= 1'b0;
    $display("test events done");
    pm <= CTC_PM_STOP;
    repeat (4) @(posedge aclk);
    cmp(32'(clkr), 32'h1);
    repeat (200) @(posedge aclk);
    cmp(32'(clkr), 32'h0);
    cmp(32'(bias), 32'h0);
    wk <= 1'b1;
    repeat (4) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      dom <= !i[0];
      // long phases leave room for filter lag on random ticks
      repeat (30) @(posedge aclk);
    end
    dom <= 1'b0;
    repeat (4) @(posedge aclk);
    cmp(32'(wake), 32'h1);
    rd_chk(`CTC_FLAGS_OFS, 32'h808, 32'h808);
    wrst_n <= 1'b0;
    @(posedge aclk);
    wrst_n <= 1'b1;
    repeat (2) @(posedge aclk);
    cmp(32'(wake), 32'h0);
    pdown <= 1'b1;
    @(posedge aclk);
    pdown <= 1'b0;
    @(posedge aclk);
    rd_chk(`CTC_CTRL_OFS, 32'hf, 32'h0);
    $display("test power modes and wake done");
    final_report();
  end
endmodule
`default_nettype wire

//--- rtl/ctc_bus_transceiver.sv
// control logic of the bus transceiver: modes, events, register file
// assumes bus_rx_in is the receiver comparator (1 = recessive), inputs
// synchronous to aclk, and ticks from the filter and silence clocks
//
// Contract
// - one interrupt output for four events
// - each event sets its interrupt flag
// - mask bit gates event onto interrupt
// - interrupt follows event, not flag state
// - write one to clear bit clears flag
// - write one to force bit emulates event
// - separate sticky state bit per event
// - wake reset only touches wake logic
// - disabled after power-up, reset at power-down
// - active mode honours software mode choice
// - stop mode forces sleep or off
// - sleep mode forces sleep or off
// - bias and clock held through silence time; bias only if wake enabled, off mode drops it
// - fail-sleep forces off, no bus wake
// - mode from enable, mode field, wake-enable
// - four transmit sources, shared receive output
// - wake-detected output on bus wake-up
// - silence ticks and filter ticks timed separately
// - registers reached over a slave bus port
// - en+01 rx-only, en+11 normal, else off/sleep
// - off mode tristates driver, ignores bus
// - long dominant receive flags bus timeout
// - transmit timeout blocks until clear and recessive
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`include "ctc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ctc_bus_transceiver #(
  parameter int unsigned TWAKE2_CYC = `CTC_TWAKE2_CYC,
  parameter int unsigned BUS_TO_CYC = `CTC_BUS_TO_CYC,
  parameter int unsigned TXD_TO_CYC = `CTC_TXD_TO_CYC
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  wake_resetn,
  input  wire logic                  power_down,
  input  wire ctc_pkg::ctc_pmode_t   pmode,
  input  wire logic                  wake_en_in,
  input  wire logic                  silence_tick,
  input  wire logic                  filter_tick,
  input  wire logic                  supply_undervoltage_in,
  input  wire logic                  overtemp_in,
  input  wire logic                  tx_in_protocol,
  input  wire logic                  tx_in_uart,
  input  wire logic                  tx_in_timer,
  input  wire logic                  tx_in_gpio,
  input  wire logic                  bus_rx_in,
  input  wire ctc_pkg::ctc_axi_req_t axi_req,
  output wire ctc_pkg::ctc_axi_rsp_t axi_rsp,
  output wire logic                  rx_data,
  output wire logic                  bus_tx_out,
  output wire logic                  bus_drv_en,
  output wire logic                  bus_bias_en,
  output wire logic                  bus_wake_detected,
  output wire logic                  core_clk_run,
  output wire logic                  irq
);
  import ctc_pkg::*;

  localparam logic [15:0] T1 = 16'(`CTC_TWAKE1_CYC);
  localparam logic [15:0] T2 = 16'(TWAKE2_CYC);
  localparam logic [15:0] BTO = 16'(BUS_TO_CYC);
  localparam logic [15:0] TTO = 16'(TXD_TO_CYC);

  ctc_state_t s_q;
  ctc_state_t s_d;

  ctc_opmode_t fallback;
  ctc_opmode_t sel;
  logic [3:0]  ev;
  logic [3:0]  force_ev;
  logic [3:0]  clr_is;
  logic [3:0]  clr_sts;
  logic [15:0] bm;
  logic [15:0] wd;
  logic        txc;
  logic        rx_on;
  logic        blocked;
  logic        wr;
  logic        rd;
  logic        expect_lvl;
  logic        keep_rdy;

  always_comb begin
    s_d      = s_q;
    ev       = '0;
    force_ev = '0;
    clr_is   = '0;
    clr_sts  = '0;
    keep_rdy = 1'b0;

    // mode select
    fallback = wake_en_in ? CTC_SLEEP : CTC_OFF;
    sel      = fallback;
    unique case (pmode)
      CTC_PM_ACTIVE: begin
        if (s_q.ctrl_en && s_q.ctrl_mode == `CTC_MODE_RXONLY) begin
          sel = CTC_RXONLY;
        end else if (s_q.ctrl_en && s_q.ctrl_mode == `CTC_MODE_NORMAL) begin
          sel = CTC_NORMAL;
        end
      end
      CTC_PM_STOP:      sel = fallback;
      CTC_PM_SLEEP:     sel = fallback;
      CTC_PM_FAILSLEEP: sel = CTC_OFF;
    endcase
    s_d.opm = sel;
    s_d.pm  = pmode;

    // silence window after leaving active mode for stop or sleep
    if (s_q.pm == CTC_PM_ACTIVE &&
        (pmode == CTC_PM_STOP || pmode == CTC_PM_SLEEP)) begin
      s_d.sil_run = 1'b1;
      s_d.sil_cnt = `CTC_SILENCE_TICKS;
    end else if (pmode == CTC_PM_ACTIVE || pmode == CTC_PM_FAILSLEEP) begin
      s_d.sil_run = 1'b0;
    end else if (s_q.sil_run && silence_tick) begin
      s_d.sil_cnt = s_q.sil_cnt - 8'h01;
      if (s_q.sil_cnt <= 8'h01) begin
        s_d.sil_run = 1'b0;
      end
    end
    s_d.clk_run = (pmode == CTC_PM_ACTIVE) || s_d.sil_run;

    // receive filter: two equal samples on the filter tick
    if (filter_tick) begin
      s_d.rx_s = bus_rx_in;
      if (bus_rx_in == s_q.rx_s) begin
        s_d.rx_f = bus_rx_in;
      end
    end
    rx_on      = s_q.opm == CTC_NORMAL || s_q.opm == CTC_RXONLY;
    s_d.rx_out = rx_on ? s_q.rx_f : 1'b1;

    // bus dominant timeout, report only
    if (rx_on && !s_q.rx_f) begin
      if (s_q.bus_cnt != 16'hFFFF) begin
        s_d.bus_cnt = s_q.bus_cnt + 16'h0001;
      end
      ev[`CTC_EV_BUS] = s_q.bus_cnt == BTO - 16'h0001;
    end else begin
      s_d.bus_cnt = '0;
    end

    // transmit path: wired-and of four sources, low is dominant
    txc = tx_in_protocol & tx_in_uart & tx_in_timer & tx_in_gpio;
    if (s_q.opm == CTC_NORMAL && s_q.ctrl_txto && !txc) begin
      if (s_q.tx_cnt != 16'hFFFF) begin
        s_d.tx_cnt = s_q.tx_cnt + 16'h0001;
      end
      ev[`CTC_EV_TXD] = s_q.tx_cnt == TTO - 16'h0001;
    end else begin
      s_d.tx_cnt = '0;
    end

    s_d.ot_s       = overtemp_in;
    ev[`CTC_EV_OT] = overtemp_in && !s_q.ot_s;
    s_d.uv         = supply_undervoltage_in;

    // re-arm only after a recessive level once every blocker is gone
    blocked = s_q.opm != CTC_NORMAL || s_q.uv ||
              s_q.state_bit[`CTC_EV_TXD] || s_q.state_bit[`CTC_EV_OT];
    s_d.tx_arm = !blocked && (s_q.tx_arm || txc);
    s_d.tx_out = s_q.tx_arm && !blocked ? txc : 1'b1;
    s_d.drv_en = s_q.opm == CTC_NORMAL;
    s_d.bias   = rx_on || (s_q.opm == CTC_SLEEP &&
                 (s_q.sil_run || s_q.wake_det));

    // wake-up pattern: dominant, recessive, dominant, each over t1
    expect_lvl = s_q.wk == CTC_WK_REC;
    if (s_q.opm != CTC_SLEEP) begin
      s_d.wk       = CTC_WK_IDLE;
      s_d.wk_cnt   = '0;
      s_d.wake_det = 1'b0;
    end else begin
      unique case (s_q.wk)
        CTC_WK_IDLE: begin
          s_d.wk_cnt = '0;
          if (!s_q.rx_f) begin
            s_d.wk = CTC_WK_DOM1;
          end
        end
        default: begin
          s_d.wk_cnt = s_q.wk_cnt + 16'h0001;
          if (s_q.wk == CTC_WK_DOM2 && s_q.wk_cnt >= T1) begin
            s_d.wk          = CTC_WK_IDLE;
            s_d.wake_det    = 1'b1;
            ev[`CTC_EV_WAKE] = 1'b1;
          end else if (s_q.rx_f == expect_lvl) begin
            if (s_q.wk_cnt >= T2 - 16'h0001) begin
              s_d.wk = CTC_WK_IDLE;
            end
          end else begin
            s_d.wk_cnt = '0;
            if (s_q.wk_cnt < T1) begin
              s_d.wk = CTC_WK_IDLE;
            end else if (s_q.wk == CTC_WK_DOM1) begin
              s_d.wk = CTC_WK_REC;
            end else begin
              s_d.wk = CTC_WK_DOM2;
            end
          end
        end
      endcase
    end

    // register writes
    wr = s_q.aw_rdy && axi_req.awvalid && axi_req.wvalid;
    bm = {{8{axi_req.wstrb[1]}}, {8{axi_req.wstrb[0]}}};
    wd = axi_req.wdata[15:0] & bm;
    if (wr) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = `CTC_RESP_OKAY;
      case (axi_req.awaddr)
        `CTC_CTRL_OFS: begin
          if (axi_req.wstrb[0]) begin
            s_d.ctrl_en   = wd[`CTC_CTRL_EN_B];
            s_d.ctrl_mode = wd[`CTC_CTRL_MODE_L +: 2];
            s_d.ctrl_txto = wd[`CTC_CTRL_TXTO_B];
          end
        end
        `CTC_CLEAR_OFS: begin
          clr_is  = wd[3:0];
          clr_sts = wd[`CTC_STS_L +: 4];
        end
        `CTC_FORCE_OFS: force_ev = wd[3:0];
        `CTC_MASK_OFS: begin
          if (axi_req.wstrb[0]) begin
            s_d.mask = wd[3:0];
          end
        end
        `CTC_STAT_OFS, `CTC_FLAGS_OFS: s_d.bresp = `CTC_RESP_OKAY;
        default: s_d.bresp = `CTC_RESP_SLVERR;
      endcase
    end else if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end
    // ready pulses one cycle once both halves are offered
    s_d.aw_rdy = !s_q.aw_rdy && !s_d.bvalid && !s_q.bvalid &&
                 axi_req.awvalid && axi_req.wvalid;

    // timeout state bit only clears once transmit is recessive again
    clr_sts[`CTC_EV_TXD] = clr_sts[`CTC_EV_TXD] & txc;

    // set wins over clear
    s_d.irq_flag  = (s_q.irq_flag & ~clr_is) | ev | force_ev;
    s_d.state_bit = (s_q.state_bit & ~clr_sts) | ev;
    s_d.irq = |((ev | force_ev) & s_q.mask);

    // register reads
    rd = s_q.ar_rdy && axi_req.arvalid;
    if (rd) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `CTC_RESP_OKAY;
      s_d.rdata  = '0;
      case (axi_req.araddr)
        `CTC_CTRL_OFS: begin
          s_d.rdata[`CTC_CTRL_EN_B]        = s_q.ctrl_en;
          s_d.rdata[`CTC_CTRL_MODE_L +: 2] = s_q.ctrl_mode;
          s_d.rdata[`CTC_CTRL_TXTO_B]      = s_q.ctrl_txto;
        end
        `CTC_STAT_OFS: begin
          s_d.rdata[7:0] = {s_q.sil_run, s_q.wake_det, s_q.bias,
                            s_q.drv_en, s_q.tx_arm, s_q.rx_f, s_q.opm};
        end
        `CTC_FLAGS_OFS: begin
          s_d.rdata[3:0]            = s_q.irq_flag;
          s_d.rdata[`CTC_STS_L +: 4] = s_q.state_bit;
          s_d.rdata[`CTC_UV_B]       = s_q.uv;
        end
        `CTC_MASK_OFS:  s_d.rdata[3:0] = s_q.mask;
        `CTC_CLEAR_OFS, `CTC_FORCE_OFS: s_d.rresp = `CTC_RESP_OKAY;
        default: s_d.rresp = `CTC_RESP_SLVERR;
      endcase
    end else if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.ar_rdy = !s_q.ar_rdy && !s_d.rvalid && !s_q.rvalid &&
                 axi_req.arvalid;

    // logic reset carries the wake detector over; the off mode it loads clears wake_det a cycle later
    if (!aresetn || power_down) begin
      keep_rdy = s_d.wake_det;
      s_d      = '0;
      {s_d.ctrl_txto, s_d.ctrl_mode, s_d.ctrl_en} = `CTC_CTRL_RST;
      s_d.mask      = `CTC_MASK_RST;
      s_d.wk        = s_q.wk;
      s_d.wk_cnt    = s_q.wk_cnt;
      s_d.wake_det  = keep_rdy;
      s_d.opm       = CTC_OFF;
      s_d.pm        = CTC_PM_ACTIVE;
      s_d.rx_s      = 1'b1;
      s_d.rx_f      = 1'b1;
      s_d.tx_out    = 1'b1;
      s_d.rx_out    = 1'b1;
      s_d.clk_run   = 1'b1;
    end
    if (!wake_resetn || power_down) begin
      s_d.wk       = CTC_WK_IDLE;
      s_d.wk_cnt   = '0;
      s_d.wake_det = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign axi_rsp.awready   = s_q.aw_rdy;
  assign axi_rsp.wready    = s_q.aw_rdy;
  assign axi_rsp.bvalid    = s_q.bvalid;
  assign axi_rsp.bresp     = s_q.bresp;
  assign axi_rsp.arready   = s_q.ar_rdy;
  assign axi_rsp.rvalid    = s_q.rvalid;
  assign axi_rsp.rdata     = s_q.rdata;
  assign axi_rsp.rresp     = s_q.rresp;
  assign rx_data           = s_q.rx_out;
  assign bus_tx_out        = s_q.tx_out;
  assign bus_drv_en        = s_q.drv_en;
  assign bus_bias_en       = s_q.bias;
  assign bus_wake_detected = s_q.wake_det;
  assign core_clk_run      = s_q.clk_run;
  assign irq               = s_q.irq;

endmodule

`default_nettype wire

//--- rtl/ctc_cfg.svh
// constants for the bus transceiver control block
// assumes a 10 MHz aclk and an 8-bit AXI4-Lite byte address
`ifndef CTC_CFG_SVH
`define CTC_CFG_SVH

`define CTC_CTRL_OFS      8'h00
`define CTC_STAT_OFS      8'h04
`define CTC_FLAGS_OFS     8'h08
`define CTC_CLEAR_OFS     8'h0C
`define CTC_FORCE_OFS     8'h10
`define CTC_MASK_OFS      8'h14

`define CTC_CTRL_EN_B     0
`define CTC_CTRL_MODE_L   1
`define CTC_CTRL_TXTO_B   3
`define CTC_MODE_RXONLY   2'h1
`define CTC_MODE_NORMAL   2'h3
`define CTC_CTRL_RST      4'h0
`define CTC_MASK_RST      4'h0

`define CTC_EV_BUS        0
`define CTC_EV_TXD        1
`define CTC_EV_OT         2
`define CTC_EV_WAKE       3
`define CTC_STS_L         8
`define CTC_UV_B          12

`define CTC_RESP_OKAY     2'h0
`define CTC_RESP_SLVERR   2'h2

`define CTC_CLK_KHZ       10000
`define CTC_TWAKE1_NS     1200
`define CTC_TWAKE1_CYC    ((`CTC_TWAKE1_NS*`CTC_CLK_KHZ+999999)/1000000)
`define CTC_TWAKE2_US     2000
`define CTC_TWAKE2_CYC    ((`CTC_TWAKE2_US*`CTC_CLK_KHZ)/1000)
`define CTC_BUS_TO_US     1000
`define CTC_BUS_TO_CYC    ((`CTC_BUS_TO_US*`CTC_CLK_KHZ+999)/1000)
`define CTC_TXD_TO_US     1000
`define CTC_TXD_TO_CYC    ((`CTC_TXD_TO_US*`CTC_CLK_KHZ+999)/1000)
`define CTC_SILENCE_TICKS 8'h10

`endif

//--- rtl/ctc_pkg.sv
// types shared by the bus transceiver control block
// assumes ctc_cfg.svh holds the numbers
package ctc_pkg;

  typedef enum logic [1:0] {
    CTC_OFF,
    CTC_RXONLY,
    CTC_NORMAL,
    CTC_SLEEP
  } ctc_opmode_t;

  typedef enum logic [1:0] {
    CTC_PM_ACTIVE,
    CTC_PM_STOP,
    CTC_PM_SLEEP,
    CTC_PM_FAILSLEEP
  } ctc_pmode_t;

  typedef enum logic [1:0] {
    CTC_WK_IDLE,
    CTC_WK_DOM1,
    CTC_WK_REC,
    CTC_WK_DOM2
  } ctc_wake_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } ctc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ctc_axi_rsp_t;

  typedef struct packed {
    logic        ctrl_en;
    logic [1:0]  ctrl_mode;
    logic        ctrl_txto;
    logic [3:0]  mask;
    logic [3:0]  irq_flag;
    logic [3:0]  state_bit;
    ctc_opmode_t opm;
    ctc_pmode_t  pm;
    logic        sil_run;
    logic [7:0]  sil_cnt;
    logic        rx_s;
    logic        rx_f;
    logic [15:0] tx_cnt;
    logic [15:0] bus_cnt;
    logic        tx_arm;
    logic        tx_out;
    logic        drv_en;
    logic        bias;
    logic        rx_out;
    logic        ot_s;
    logic        uv;
    ctc_wake_t   wk;
    logic [15:0] wk_cnt;
    logic        wake_det;
    logic        irq;
    logic        clk_run;
    logic        aw_rdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        ar_rdy;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } ctc_state_t;

endpackage
